// file: cfm_pkg.sv
// constants, register map and state encoding of the clock frequency meter
package cfm_pkg;
  // bus geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  // register byte offsets
  localparam logic [7:0] OFF_CTRLA = 8'h00; // first control register
  localparam logic [7:0] OFF_CTRL2 = 8'h04; // second_control_register
  localparam logic [7:0] OFF_CFG1 = 8'h08; // first_configuration_register
  localparam logic [7:0] OFF_IEN_CLR = 8'h0c; // interrupt_enable_clear_register
  localparam logic [7:0] OFF_IEN_SET = 8'h10; // interrupt_enable_set_register
  localparam logic [7:0] OFF_IRQ_FLAG = 8'h14; // interrupt_flag_register
  localparam logic [7:0] OFF_STATUS = 8'h18; // status register
  localparam logic [7:0] OFF_VALUE = 8'h1c; // result register
  // field positions
  localparam int ENABLE_BIT = 0;
  localparam int SWRST_BIT = 1;
  localparam int START_BIT = 0;
  localparam int DONE_BIT = 0;
  localparam int BUSY_BIT = 0;
  localparam int WRAP_BIT = 1;
  localparam int STRB_LOW = 0; // byte lane holding every narrow field
  // field widths
  localparam int WIN_W = 8;
  localparam int VALUE_W = 24;
  // reset values and helpers
  localparam logic [WIN_W-1:0] WIN_RST = 8'h00;
  localparam logic [WIN_W-1:0] REF_ONE = 8'h01;
  localparam logic [VALUE_W-1:0] VALUE_RST = 24'h000000;
  localparam logic [VALUE_W-1:0] VALUE_ONE = 24'h000001;
  localparam logic [VALUE_W-1:0] VALUE_MAX = 24'hffffff;
  localparam logic [DATA_W-1:0] WORD_ZERO = 32'h00000000;
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
  // measurement sequence
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_ARM = 2'b01,
    ST_COUNT = 2'b10,
    ST_FINISH = 2'b11
  } cfm_state_t;
endpackage

// file: cfm_sync_edge.sv
// two-stage synchroniser with rising edge detector for a foreign clock pin
`timescale 1ns/1ps
`default_nettype none
module cfm_sync_edge (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic asyncIn,
  output logic rise
);
  logic [2:0] stage; // stage[0] is read only by stage[1]
  logic [2:0] next_stage;

  // shift the pin through the chain
  always_comb begin
    next_stage = {stage[1:0], asyncIn};
  end

  // register the chain, cleared on reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      stage <= 3'h0;
    end else begin
      stage <= next_stage;
    end
  end

  // edge seen between the second and third stage
  assign rise = stage[1] & ~stage[2];

  property p_rise_single;
    @(posedge sys_clk) disable iff (!rst_b) rise |=> !rise;
  endproperty
  a_rise_single: assert property (p_rise_single) else $error("edge pulse longer than one cycle");
endmodule // cfm_sync_edge
`default_nettype wire

// file: cfm_edge_counter.sv
// 24-bit edge counter with wrap detection
`timescale 1ns/1ps
`default_nettype none
module cfm_edge_counter (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic clear,
  input wire logic inc,
  output logic [cfm_pkg::VALUE_W-1:0] count,
  output logic wrap
);
  logic [cfm_pkg::VALUE_W-1:0] next_count;

  // clear has priority over counting
  always_comb begin
    next_count = count;
    if (clear) begin
      next_count = cfm_pkg::VALUE_RST;
    end else if (inc) begin
      next_count = count + cfm_pkg::VALUE_ONE;
    end
  end

  // counter register
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      count <= cfm_pkg::VALUE_RST;
    end else begin
      count <= next_count;
    end
  end

  // counting past the top would roll over
  assign wrap = inc && !clear && (count == cfm_pkg::VALUE_MAX);

  property p_count_step;
    @(posedge sys_clk) disable iff (!rst_b)
      (inc && !clear) |=> count == $past(count) + cfm_pkg::VALUE_ONE;
  endproperty
  a_count_step: assert property (p_count_step) else $error("counter did not step by one");

  property p_wrap_top;
    @(posedge sys_clk) disable iff (!rst_b) wrap |=> count == cfm_pkg::VALUE_RST;
  endproperty
  a_wrap_top: assert property (p_wrap_top) else $error("wrap without rollover"); // [R13]
endmodule // cfm_edge_counter
`default_nettype wire

// file: clock_frequency_meter.sv
// clock frequency meter top: axi4-lite registers, measurement sequence, interrupt
//
// Contract
// R1: window length is reference_cycle_count reference periods
// R2: software sets reference count before enabling
// R3: start bit write begins measurement when enabled
// R4: busy set at start, cleared at completion
// R5: done flag set; irq only if enabled
// R6: 24-bit result; freq = result/count times fref
// R7: overflow flag in status, cleared writing one
// R8: after overflow, adjust setup then clear flag
// R9: enable-set write enables, enable-clear write disables
// R10: irq holds until cleared, disabled or reset
// R11: all requests ORed onto one line
// R12: keeps measuring in idle sleep; wakes device
// R13: overflow on wrap; busy drop with done
`timescale 1ns/1ps
`default_nettype none
module clock_frequency_meter (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic measuredClock,
  input wire logic referenceClock,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [cfm_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [cfm_pkg::DATA_W-1:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [cfm_pkg::ADDR_W-1:0] s_axi_araddr,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [cfm_pkg::DATA_W-1:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic irq,
  output logic wakeReq
);
  // synchronised edges of the two foreign clocks
  logic msrRise;
  logic refRise;
  // edge counter hookup
  logic cntClear;
  logic cntInc;
  logic [cfm_pkg::VALUE_W-1:0] cntValue;
  logic cntWrap;
  // write channel holding state
  logic awHeld, next_awHeld;
  logic [cfm_pkg::ADDR_W-1:0] awAddr, next_awAddr;
  logic wHeld, next_wHeld;
  logic [cfm_pkg::DATA_W-1:0] wData, next_wData;
  logic [3:0] wStrb, next_wStrb;
  logic bValid, next_bValid;
  logic [1:0] bResp, next_bResp;
  // read channel state
  logic rValid, next_rValid;
  logic [cfm_pkg::DATA_W-1:0] rData, next_rData;
  logic [1:0] rResp, next_rResp;
  // decoded write strobes, one cycle each
  logic doWrite;
  logic lowLane;
  logic hitCtrla, hitStart, hitWinLen, hitIenClr, hitIenSet, hitFlag, hitStatus;
  logic softRst;
  logic startReq;
  logic doneClr;
  logic wrapClr;
  logic mapped;
  // software visible state
  logic enable, next_enable;
  logic [cfm_pkg::WIN_W-1:0] winLen, next_winLen;
  logic doneIen, next_doneIen;
  logic doneFlag, next_doneFlag;
  logic wrapFlag, next_wrapFlag;
  logic [cfm_pkg::VALUE_W-1:0] value, next_value;
  // measurement sequence state
  cfm_pkg::cfm_state_t state, next_state;
  logic [cfm_pkg::WIN_W-1:0] refSeen, next_refSeen;
  logic windowEnd;
  logic busy;

  // pin synchronisers for measured and reference clocks
  cfm_sync_edge u_msrSync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .asyncIn(measuredClock),
    .rise(msrRise)
  );
  cfm_sync_edge u_refSync (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .asyncIn(referenceClock),
    .rise(refRise)
  );

  // measured edge counter
  cfm_edge_counter u_counter (
    .sys_clk(sys_clk),
    .rst_b(rst_b),
    .clear(cntClear),
    .inc(cntInc),
    .count(cntValue),
    .wrap(cntWrap)
  );

  // bus handshakes, address and data taken in either order
  assign s_axi_awready = !awHeld && !bValid;
  assign s_axi_wready = !wHeld && !bValid;
  assign s_axi_bvalid = bValid;
  assign s_axi_bresp = bResp;
  assign s_axi_arready = !rValid;
  assign s_axi_rvalid = rValid;
  assign s_axi_rdata = rData;
  assign s_axi_rresp = rResp;

  // write decode, acts once both halves are held
  assign doWrite = awHeld && wHeld && !bValid;
  assign lowLane = wStrb[cfm_pkg::STRB_LOW];
  assign hitCtrla = doWrite && lowLane && (awAddr == cfm_pkg::OFF_CTRLA);
  assign hitStart = doWrite && lowLane && (awAddr == cfm_pkg::OFF_CTRL2);
  assign hitWinLen = doWrite && lowLane && (awAddr == cfm_pkg::OFF_CFG1);
  assign hitIenClr = doWrite && lowLane && (awAddr == cfm_pkg::OFF_IEN_CLR);
  assign hitIenSet = doWrite && lowLane && (awAddr == cfm_pkg::OFF_IEN_SET);
  assign hitFlag = doWrite && lowLane && (awAddr == cfm_pkg::OFF_IRQ_FLAG);
  assign hitStatus = doWrite && lowLane && (awAddr == cfm_pkg::OFF_STATUS);
  assign softRst = hitCtrla && wData[cfm_pkg::SWRST_BIT];
  assign startReq = hitStart && wData[cfm_pkg::START_BIT]; // [R3]
  assign doneClr = hitFlag && wData[cfm_pkg::DONE_BIT];
  assign wrapClr = hitStatus && wData[cfm_pkg::WRAP_BIT]; // [R7]

  // known write addresses, others answer slverr
  always_comb begin
    unique case (awAddr)
      cfm_pkg::OFF_CTRLA, cfm_pkg::OFF_CTRL2, cfm_pkg::OFF_CFG1,
      cfm_pkg::OFF_IEN_CLR, cfm_pkg::OFF_IEN_SET, cfm_pkg::OFF_IRQ_FLAG,
      cfm_pkg::OFF_STATUS, cfm_pkg::OFF_VALUE: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // write channel next state
  always_comb begin
    next_awHeld = awHeld;
    next_awAddr = awAddr;
    next_wHeld = wHeld;
    next_wData = wData;
    next_wStrb = wStrb;
    next_bValid = bValid;
    next_bResp = bResp;
    if (s_axi_awvalid && s_axi_awready) begin
      next_awHeld = 1'b1;
      next_awAddr = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      next_wHeld = 1'b1;
      next_wData = s_axi_wdata;
      next_wStrb = s_axi_wstrb;
    end
    if (doWrite) begin
      // response after both halves, writes to the result are ignored
      next_awHeld = 1'b0;
      next_wHeld = 1'b0;
      next_bValid = 1'b1;
      next_bResp = mapped ? cfm_pkg::RESP_OKAY : cfm_pkg::RESP_SLVERR;
    end else if (bValid && s_axi_bready) begin
      next_bValid = 1'b0;
    end
  end

  // write channel registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      awHeld <= 1'b0;
      awAddr <= cfm_pkg::OFF_CTRLA;
      wHeld <= 1'b0;
      wData <= cfm_pkg::WORD_ZERO;
      wStrb <= 4'h0;
      bValid <= 1'b0;
      bResp <= cfm_pkg::RESP_OKAY;
    end else begin
      awHeld <= next_awHeld;
      awAddr <= next_awAddr;
      wHeld <= next_wHeld;
      wData <= next_wData;
      wStrb <= next_wStrb;
      bValid <= next_bValid;
      bResp <= next_bResp;
    end
  end

  // read mux, answer one cycle after the address is taken
  always_comb begin
    next_rValid = rValid;
    next_rData = rData;
    next_rResp = rResp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rValid = 1'b1;
      next_rData = cfm_pkg::WORD_ZERO;
      next_rResp = cfm_pkg::RESP_OKAY;
      unique case (s_axi_araddr)
        cfm_pkg::OFF_CTRLA: next_rData[cfm_pkg::ENABLE_BIT] = enable;
        cfm_pkg::OFF_CTRL2: next_rData = cfm_pkg::WORD_ZERO; // write-only strobe
        cfm_pkg::OFF_CFG1: next_rData[cfm_pkg::WIN_W-1:0] = winLen;
        cfm_pkg::OFF_IEN_CLR: next_rData[cfm_pkg::DONE_BIT] = doneIen;
        cfm_pkg::OFF_IEN_SET: next_rData[cfm_pkg::DONE_BIT] = doneIen;
        cfm_pkg::OFF_IRQ_FLAG: next_rData[cfm_pkg::DONE_BIT] = doneFlag; // [R11]
        cfm_pkg::OFF_STATUS: begin
          next_rData[cfm_pkg::BUSY_BIT] = busy; // [R4]
          next_rData[cfm_pkg::WRAP_BIT] = wrapFlag; // [R7]
        end
        cfm_pkg::OFF_VALUE: next_rData[cfm_pkg::VALUE_W-1:0] = value; // [R6]
        default: next_rResp = cfm_pkg::RESP_SLVERR;
      endcase
    end else if (rValid && s_axi_rready) begin
      next_rValid = 1'b0;
    end
  end

  // read channel registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      rValid <= 1'b0;
      rData <= cfm_pkg::WORD_ZERO;
      rResp <= cfm_pkg::RESP_OKAY;
    end else begin
      rValid <= next_rValid;
      rData <= next_rData;
      rResp <= next_rResp;
    end
  end

  // window ends on the reference edge that completes the count
  assign windowEnd = (state == cfm_pkg::ST_COUNT) && refRise &&
                     ((refSeen + cfm_pkg::REF_ONE) >= winLen); // [R1]
  assign busy = (state != cfm_pkg::ST_IDLE);
  assign cntClear = (state == cfm_pkg::ST_IDLE);
  assign cntInc = (state == cfm_pkg::ST_COUNT) && msrRise;

  // measurement sequence, runs regardless of sleep state [R12]
  always_comb begin
    next_state = state;
    next_refSeen = refSeen;
    unique case (state)
      cfm_pkg::ST_IDLE: begin
        if (startReq && enable) begin
          next_state = cfm_pkg::ST_ARM; // [R3] [R4]
        end
      end
      cfm_pkg::ST_ARM: begin
        // align window start to a reference edge
        next_refSeen = cfm_pkg::WIN_RST;
        if (refRise) begin
          next_state = cfm_pkg::ST_COUNT;
        end
      end
      cfm_pkg::ST_COUNT: begin
        if (windowEnd) begin
          next_state = cfm_pkg::ST_FINISH; // [R1]
        end else if (refRise) begin
          next_refSeen = refSeen + cfm_pkg::REF_ONE;
        end
      end
      cfm_pkg::ST_FINISH: next_state = cfm_pkg::ST_IDLE; // [R13]
    endcase
    if (softRst || !enable) begin
      next_state = cfm_pkg::ST_IDLE; // abort on disable or software reset
    end
  end

  // configuration, enables, flags and result
  always_comb begin
    next_enable = enable;
    next_winLen = winLen;
    next_doneIen = doneIen;
    next_doneFlag = doneFlag;
    next_wrapFlag = wrapFlag;
    next_value = value;
    if (hitCtrla) begin
      next_enable = wData[cfm_pkg::ENABLE_BIT];
    end
    if (hitWinLen && !enable) begin
      next_winLen = wData[cfm_pkg::WIN_W-1:0]; // [R2]
    end
    if (hitIenClr && wData[cfm_pkg::DONE_BIT]) begin
      next_doneIen = 1'b0; // [R9]
    end
    if (hitIenSet && wData[cfm_pkg::DONE_BIT]) begin
      next_doneIen = 1'b1; // [R9]
    end
    // set wins over a clear in the same cycle
    if (doneClr) begin
      next_doneFlag = 1'b0;
    end
    if (state == cfm_pkg::ST_FINISH) begin
      next_doneFlag = 1'b1; // [R5] [R13]
      next_value = cntValue; // [R6]
    end
    if (wrapClr) begin
      next_wrapFlag = 1'b0; // [R7]
    end
    if (cntWrap) begin
      next_wrapFlag = 1'b1; // [R13]
    end
    if (softRst) begin
      next_enable = 1'b0;
      next_winLen = cfm_pkg::WIN_RST;
      next_doneIen = 1'b0;
      next_doneFlag = 1'b0;
      next_wrapFlag = 1'b0;
      next_value = cfm_pkg::VALUE_RST;
    end
  end

  // state registers
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      state <= cfm_pkg::ST_IDLE;
      refSeen <= cfm_pkg::WIN_RST;
      enable <= 1'b0;
      winLen <= cfm_pkg::WIN_RST;
      doneIen <= 1'b0;
      doneFlag <= 1'b0;
      wrapFlag <= 1'b0;
      value <= cfm_pkg::VALUE_RST;
    end else begin
      state <= next_state;
      refSeen <= next_refSeen;
      enable <= next_enable;
      winLen <= next_winLen;
      doneIen <= next_doneIen;
      doneFlag <= next_doneFlag;
      wrapFlag <= next_wrapFlag;
      value <= next_value;
    end
  end

  // single combined request, also the idle wake-up
  assign irq = doneFlag && doneIen; // [R5] [R10] [R11]
  assign wakeReq = irq; // [R12]

  property p_start_busy;
    @(posedge sys_clk) disable iff (!rst_b)
      (state == cfm_pkg::ST_IDLE && startReq && enable && !softRst) |=> busy;
  endproperty
  a_start_busy: assert property (p_start_busy) else $error("start did not raise busy"); // [R4]

  property p_finish_done;
    @(posedge sys_clk) disable iff (!rst_b)
      (state == cfm_pkg::ST_FINISH && !softRst) |=> (doneFlag && !busy && value == $past(cntValue));
  endproperty
  a_finish_done: assert property (p_finish_done) else $error("completion not reported"); // [R13]

  property p_irq_hold;
    @(posedge sys_clk) disable iff (!rst_b)
      (irq && !doneClr && !hitIenClr && !softRst) |=> irq;
  endproperty
  a_irq_hold: assert property (p_irq_hold) else $error("irq dropped without cause"); // [R10]

  property p_irq_mask;
    @(posedge sys_clk) disable iff (!rst_b) (doneFlag && !doneIen) |-> !irq;
  endproperty
  a_irq_mask: assert property (p_irq_mask) else $error("masked irq raised"); // [R5]

  property p_ovf_set;
    @(posedge sys_clk) disable iff (!rst_b) (cntWrap && !softRst) |=> wrapFlag;
  endproperty
  a_ovf_set: assert property (p_ovf_set) else $error("wrap did not set overflow"); // [R7]

  property p_winlen_locked;
    @(posedge sys_clk) disable iff (!rst_b) (enable && !softRst) |=> $stable(winLen);
  endproperty
  a_winlen_locked: assert property (p_winlen_locked) else $error("count changed while on"); // [R2]

  property p_window_end;
    @(posedge sys_clk) disable iff (!rst_b)
      (windowEnd && enable && !softRst) |=> state == cfm_pkg::ST_FINISH ##1 !busy;
  endproperty
  a_window_end: assert property (p_window_end) else $error("window did not close"); // [R1]

  property p_ien_set;
    @(posedge sys_clk) disable iff (!rst_b)
      (hitIenSet && wData[cfm_pkg::DONE_BIT] && !softRst) |=> doneIen;
  endproperty
  a_ien_set: assert property (p_ien_set) else $error("enable-set ignored"); // [R9]

  property p_write_resp;
    @(posedge sys_clk) disable iff (!rst_b) doWrite |=> s_axi_bvalid;
  endproperty
  a_write_resp: assert property (p_write_resp) else $error("write response missing");
endmodule // clock_frequency_meter
`default_nettype wire

// file: tb_top.sv
// self-checking testbench of the clock frequency meter
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  localparam logic [7:0] aCtl = 8'h00; // enable and software reset
  localparam logic [7:0] aStart = 8'h04; // start strobe
  localparam logic [7:0] aCfg = 8'h08; // window length in reference periods
  localparam logic [7:0] aIeClr = 8'h0c; // done enable, clear side
  localparam logic [7:0] aIeSet = 8'h10; // done enable, set side
  localparam logic [7:0] aFlag = 8'h14; // done flag
  localparam logic [7:0] aStat = 8'h18; // busy and overflow
  localparam logic [7:0] aVal = 8'h1c; // edge count result
  localparam int refHalf = 16; // reference clock half period in sys_clk cycles
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic measuredClock = 1'b0;
  logic referenceClock = 1'b0;
  logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h00000000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic irq, wakeReq;
  int n_mismatch = 0; // failed comparisons
  int n_checks = 0; // comparisons made
  int cyc = 0; // free-running cycle count, also the hang limit
  int msrPeriod = 8; // measured clock period in sys_clk cycles
  logic [1:0] resp; // last bus response
  logic [31:0] rd; // last read data
  clock_frequency_meter u_clock_frequency_meter (
    .sys_clk(sys_clk), .rst_b(rst_b), .measuredClock(measuredClock),
    .referenceClock(referenceClock), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_awaddr(s_axi_awaddr),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_wdata(s_axi_wdata),
    .s_axi_wstrb(s_axi_wstrb), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp), .s_axi_arvalid(s_axi_arvalid),
    .s_axi_arready(s_axi_arready), .s_axi_araddr(s_axi_araddr),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .s_axi_rresp(s_axi_rresp), .irq(irq), .wakeReq(wakeReq)
  );
  // system clock, 40 ns period
  initial begin
    forever #20 sys_clk = ~sys_clk;
  end
  // both foreign clocks derived from one cycle count; rising edges never coincide
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    referenceClock <= (cyc % (2 * refHalf)) < refHalf;
    measuredClock <= ((cyc + 1) % msrPeriod) < (msrPeriod / 2);
    if (cyc == 30000) begin
      n_mismatch = n_mismatch + 1;
      give_verdict();
    end
  end
  // expected edge count: window length times period ratio, zero behaves as one
  function automatic int expCount(input int n, input int p);
    return ((n == 0) ? 1 : n) * 2 * refHalf / p;
  endfunction
  // one comparison with report
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_checks = n_checks + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // axi4-lite write, address and data offered together
  task automatic axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    logic awDone, wDone;
    awDone = 1'b0;
    wDone = 1'b0;
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= a;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= d;
    s_axi_wstrb <= s;
    s_axi_bready <= 1'b1;
    while (!(awDone && wDone)) begin
      @(posedge sys_clk);
      if (!awDone && s_axi_awready === 1'b1) begin
        awDone = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (!wDone && s_axi_wready === 1'b1) begin
        wDone = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    do @(posedge sys_clk); while (s_axi_bvalid !== 1'b1);
    resp = s_axi_bresp;
    s_axi_bready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // axi4-lite read
  task automatic axiRead(input logic [7:0] a);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= a;
    s_axi_rready <= 1'b1;
    do @(posedge sys_clk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    while (s_axi_rvalid !== 1'b1) @(posedge sys_clk);
    rd = s_axi_rdata;
    resp = s_axi_rresp;
    s_axi_rready <= 1'b0;
    @(posedge sys_clk);
  endtask
  // read and compare
  task automatic rdChk(input string what, input logic [7:0] a, input logic [31:0] exp);
    axiRead(a);
    chk(what, exp, rd);
  endtask
  // set up, start and wait for one measurement window
  task automatic measure(input int n, input int p);
    axiWrite(aCtl, 32'h00000000, 4'hf);
    msrPeriod <= p;
    axiWrite(aCfg, n, 4'hf);
    axiWrite(aCtl, 32'h00000001, 4'hf);
    axiWrite(aStart, 32'h00000001, 4'hf);
    rdChk("busy at start", aStat, 32'h00000001);
    do axiRead(aStat); while (rd[cfm_pkg::BUSY_BIT] !== 1'b0);
    rdChk("done flag", aFlag, 32'h00000001);
  endtask
  // closing report and end of run
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  // main sequence
  initial begin
    int n, p, got, e;
    int pTab [3] = '{4, 8, 16};
    void'($urandom(32'h3e3a));
    repeat (5) @(posedge sys_clk);
    rst_b <= 1'b1;
    @(posedge sys_clk);
    // reset values and the unmapped place
    rdChk("ctrl reset", aCtl, 32'h00000000);
    rdChk("cfg reset", aCfg, 32'h00000000);
    rdChk("enable reset", aIeSet, 32'h00000000);
    rdChk("flag reset", aFlag, 32'h00000000);
    rdChk("status reset", aStat, 32'h00000000);
    rdChk("value reset", aVal, 32'h00000000);
    axiRead(8'h20);
    chk("unmapped read resp", {30'h0, cfm_pkg::RESP_SLVERR}, {30'h0, resp});
    axiWrite(8'h20, 32'h00000001, 4'hf);
    chk("unmapped write resp", {30'h0, cfm_pkg::RESP_SLVERR}, {30'h0, resp});
    // result register ignores writes but answers okay
    axiWrite(aVal, 32'h00000055, 4'hf);
    chk("result write resp", {30'h0, cfm_pkg::RESP_OKAY}, {30'h0, resp});
    rdChk("result read only", aVal, 32'h00000000);
    // start while disabled is ignored
    axiWrite(aStart, 32'h00000001, 4'hf);
    rdChk("no start when off", aStat, 32'h00000000);
    // lane zero off: no effect; window length locked while enabled
    axiWrite(aCfg, 32'h00000005, 4'he);
    rdChk("cfg lane off", aCfg, 32'h00000000);
    axiWrite(aCfg, 32'h00000003, 4'hf);
    axiWrite(aCtl, 32'h00000001, 4'hf);
    axiWrite(aCfg, $urandom % 256, 4'hf);
    rdChk("cfg locked", aCfg, 32'h00000003);
    // enabled windows: random lengths and ratios, corners 0 and 8
    axiWrite(aIeSet, 32'h00000001, 4'hf);
    for (int k = 0; k < 8; k++) begin
      n = (k == 0) ? 0 : (k == 1) ? 8 : 1 + $urandom % 8;
      p = pTab[$urandom % 3];
      measure(n, p);
      chk("irq on done", 32'h00000001, {31'h0, irq});
      chk("wake follows irq", 32'h00000001, {31'h0, wakeReq});
      rdChk("flag set", aFlag, 32'h00000001);
      axiRead(aVal);
      got = rd;
      e = expCount(n, p);
      n_checks = n_checks + 1;
      if (rd[31:24] !== 8'h00 || (^rd[23:0]) === 1'bx ||
          got < e - 1 || got > e + 1) begin
        n_mismatch = n_mismatch + 1;
        $display("wrong value result expected %0d seen %0d", e, got);
      end
      rdChk("no overflow", aStat, 32'h00000000);
      axiWrite(aFlag, 32'h00000001, 4'hf);
      chk("irq after flag clear", 32'h00000000, {31'h0, irq});
    end
    // masked done: flag without request, then enable and disable
    axiWrite(aIeClr, 32'h00000001, 4'hf);
    measure(2, 8);
    rdChk("flag while masked", aFlag, 32'h00000001);
    chk("irq masked", 32'h00000000, {31'h0, irq});
    axiWrite(aIeSet, 32'h00000001, 4'hf);
    chk("irq enabled", 32'h00000001, {31'h0, irq});
    axiWrite(aIeClr, 32'h00000001, 4'hf);
    chk("irq disabled", 32'h00000000, {31'h0, irq});
    rdChk("enable cleared", aIeSet, 32'h00000000);
    // overflow clear by writing one leaves status clean
    axiWrite(aStat, 32'h00000002, 4'hf);
    rdChk("overflow clear", aStat, 32'h00000000);
    // software reset drops flag, request and settings
    axiWrite(aIeSet, 32'h00000001, 4'hf);
    chk("irq before reset", 32'h00000001, {31'h0, irq});
    axiWrite(aCtl, 32'h00000002, 4'hf);
    chk("irq after reset", 32'h00000000, {31'h0, irq});
    rdChk("flag after reset", aFlag, 32'h00000000);
    rdChk("cfg after reset", aCfg, 32'h00000000);
    rdChk("ctrl after reset", aCtl, 32'h00000000);
    // abort by disabling in mid-window
    msrPeriod <= 4;
    axiWrite(aCfg, 32'h00000008, 4'hf);
    axiWrite(aCtl, 32'h00000001, 4'hf);
    axiWrite(aStart, 32'h00000001, 4'hf);
    axiWrite(aCtl, 32'h00000000, 4'hf);
    rdChk("busy after abort", aStat, 32'h00000000);
    rdChk("no done after abort", aFlag, 32'h00000000);
    give_verdict();
  end
endmodule // tb_top
`default_nettype wire
